// ===== hw/synth_cfg_pkg.sv
package synth_cfg_pkg;
  // ---------------------------------------------------------------
  // register file geometry
  // ---------------------------------------------------------------
  localparam int          NUM_SETS     = 4;
  localparam int          REG_COUNT    = 24;
  localparam logic [4:0]  IDX_CP_MINT  = 5'h00;
  localparam logic [4:0]  IDX_FRAC_HI  = 5'h04;
  localparam logic [4:0]  IDX_FRAC_MID = 5'h08;
  localparam logic [4:0]  IDX_POST     = 5'h0C;
  localparam logic [4:0]  IDX_RSVD_A   = 5'h10;
  localparam logic [4:0]  IDX_OUT_CTL  = 5'h11;
  localparam logic [4:0]  IDX_LOOP_CTL = 5'h12;
  localparam logic [4:0]  IDX_RSVD_B   = 5'h13;
  localparam logic [4:0]  IDX_SET_EXT  = 5'h14;
  localparam logic [4:0]  IDX_LAST     = 5'h17;
  localparam logic [4:0]  IDX_PTR      = 5'h18;
  localparam logic [4:0]  IDX_PORT     = 5'h19;
  localparam logic [4:0]  IDX_TARGET   = 5'h1A;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_CP      = 6;
  localparam int POS_MINT_LO = 1;
  localparam int POS_FRAC17  = 0;
  localparam int POS_FRAC0   = 7;
  localparam int POS_REF_OFF = 3;
  localparam int POS_Q_OFF   = 2;
  localparam int POS_SWING   = 1;
  localparam int POS_LOOP_EN = 5;
  localparam int POS_CONFIG_SET_SELECT    = 3;
  localparam int POS_P_LO    = 6;
  localparam int POS_MINT5   = 5;
  localparam int POS_MINT6   = 4;
  localparam int POS_P2      = 3;
  localparam int POS_DG      = 2;
  localparam int POS_DSM     = 1;
  localparam int POS_LF      = 0;
  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_LOOP_CTL = 8'h20;
  localparam logic [7:0] RST_SET_EXT  = 8'h02;
  localparam logic [7:0] MASK_FULL    = 8'hFF;
  localparam logic [7:0] MASK_OUT_CTL = 8'h0E;
  localparam logic [7:0] MASK_LOOP    = 8'h38;
  // ---------------------------------------------------------------
  // decode constants
  // ---------------------------------------------------------------
  localparam logic [6:0] INT_OFFSET   = 7'h04;
  localparam logic [6:0] TARGET_ADDR  = 7'h6E;
endpackage : synth_cfg_pkg

// ===== hw/synth_divider_config_decode.sv
//Contract
//- integer feedback code is seven bits, ratio spans 4 to 127
//- integer codes below four divide by code plus four
//- fractional part is the 18-bit field over two to the eighteenth
//- post ratios 2,3,4,5,6 and even 8 through 126
//- post codes 0..2 give 2, 3..5 literal, else upper six bits doubled
//- input code 000/001/010/011 divide 1/2/4/8, top bit set multiplies by two
//- two-bit set select picks one of four stored sets
//- main output disable forces true low, complement high
//- reference copy disable turns off buffered reference pair
//- loop enable low bypasses loop, reference divided by post divider
//- per-set modulator enable, default on
//- swing select high gives increased swing
//- loop filter and pump current codes passed to loop
//- serial target address is 1101110
//- data port accesses registers in ascending order after a pointer
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module synth_divider_config_decode #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // decoded loop settings
  output logic      [1:0]        active_set,
  output logic      [24:0]       feedback_ratio,
  output logic      [6:0]        post_ratio,
  output logic      [4:0]        prescale_half,
  output logic                   modulator_enable,
  output logic                   dither_gain,
  output logic                   loop_filter_sel,
  output logic      [1:0]        pump_current_sel,
  // output control
  output logic                   loop_enable,
  output logic                   synth_out_drive,
  output logic                   buffered_reference_drive,
  output logic                   swing_high,
  output logic      [6:0]        serial_target_addr
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_mask(input logic [4:0] idx);
    if (idx == synth_cfg_pkg::IDX_RSVD_A || idx == synth_cfg_pkg::IDX_RSVD_B)
      reg_mask = 8'h00;
    else if (idx == synth_cfg_pkg::IDX_OUT_CTL)
      reg_mask = synth_cfg_pkg::MASK_OUT_CTL;
    else if (idx == synth_cfg_pkg::IDX_LOOP_CTL)
      reg_mask = synth_cfg_pkg::MASK_LOOP;
    else
      reg_mask = synth_cfg_pkg::MASK_FULL;
  endfunction : reg_mask

  function automatic logic [7:0] reg_reset(input logic [4:0] idx);
    if (idx == synth_cfg_pkg::IDX_LOOP_CTL)
      reg_reset = synth_cfg_pkg::RST_LOOP_CTL;
    else if (idx >= synth_cfg_pkg::IDX_SET_EXT)
      reg_reset = synth_cfg_pkg::RST_SET_EXT;
    else
      reg_reset = synth_cfg_pkg::RST_ZERO;
  endfunction : reg_reset

  function automatic logic [6:0] int_decode(input logic [6:0] code);
    if (code < synth_cfg_pkg::INT_OFFSET)
      int_decode = code + synth_cfg_pkg::INT_OFFSET;
    else
      int_decode = code;
  endfunction : int_decode

  function automatic logic [6:0] post_decode(input logic [6:0] code);
    if (code <= 7'h02)
      post_decode = 7'h02;
    else if (code <= 7'h05)
      post_decode = code;
    else
      post_decode = {code[6:1], 1'b0};
  endfunction : post_decode

  // ratio in halves so that the multiply-by-two code stays an integer
  function automatic logic [4:0] pre_decode(input logic [2:0] code);
    if (code[2])
      pre_decode = 5'h01;
    else
      pre_decode = 5'(5'h02 << code[1:0]);
  endfunction : pre_decode

  // ---------------------------------------------------------------
  // register file and bus state
  // ---------------------------------------------------------------
  logic [7:0]  mem_q [synth_cfg_pkg::REG_COUNT];
  logic [7:0]  mem_d [synth_cfg_pkg::REG_COUNT];
  logic [4:0]  ptr_q;
  logic [4:0]  ptr_d;
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;
  logic [4:0]  idx;
  logic [4:0]  tgt;
  logic        access;
  logic        mapped;

  assign idx    = paddr[6:2];
  assign access = psel & penable & pready;
  assign tgt    = (idx == synth_cfg_pkg::IDX_PORT) ? ptr_q : idx;
  assign mapped = (paddr[ADDR_W-1:7] == '0) && (idx <= synth_cfg_pkg::IDX_TARGET);

  always_comb
  begin
    for (int i = 0; i < synth_cfg_pkg::REG_COUNT; i++)
      mem_d[i] = mem_q[i];
    ptr_d     = ptr_q;
    // answer is prepared in setup so the access phase is one cycle
    pready_d  = psel & ~penable;
    pslverr_d = psel & ~penable & ~mapped;
    prdata_d  = prdata;
    if (psel & ~penable)
    begin
      prdata_d = 32'h0000_0000;
      if (mapped && tgt <= synth_cfg_pkg::IDX_LAST)
        prdata_d = {24'h00_0000, mem_q[tgt]};
      else if (mapped && idx == synth_cfg_pkg::IDX_PTR)
        prdata_d = {27'h000_0000, ptr_q};
      else if (mapped && idx == synth_cfg_pkg::IDX_TARGET)
        prdata_d = {25'h000_0000, synth_cfg_pkg::TARGET_ADDR};
    end
    if (access && mapped)
    begin
      if (pwrite && tgt <= synth_cfg_pkg::IDX_LAST)
        mem_d[tgt] = pwdata[7:0] & reg_mask(tgt);
      if (pwrite && idx == synth_cfg_pkg::IDX_PTR)
        ptr_d = (pwdata[4:0] > synth_cfg_pkg::IDX_LAST) ? 5'h00 : pwdata[4:0];
      if (idx == synth_cfg_pkg::IDX_PORT)
        ptr_d = (ptr_q == synth_cfg_pkg::IDX_LAST) ? 5'h00 : 5'(ptr_q + 5'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < synth_cfg_pkg::REG_COUNT; i++)
        mem_q[i] <= reg_reset(5'(i));
      ptr_q   <= 5'h00;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < synth_cfg_pkg::REG_COUNT; i++)
        mem_q[i] <= mem_d[i];
      ptr_q   <= ptr_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // selected set decode
  // ---------------------------------------------------------------
  logic [1:0]  sel;
  logic [7:0]  r_cp;
  logic [7:0]  r_ext;
  logic [6:0]  int_code;
  logic [17:0] frac_code;
  logic [2:0]  pre_code;
  logic [1:0]  active_set_d;
  logic [24:0] feedback_ratio_d;
  logic [6:0]  post_ratio_d;
  logic [4:0]  prescale_half_d;

  assign sel       = mem_q[synth_cfg_pkg::IDX_LOOP_CTL][synth_cfg_pkg::POS_CONFIG_SET_SELECT +: 2];
  assign r_cp      = mem_q[synth_cfg_pkg::IDX_CP_MINT + 5'(sel)];
  assign r_ext     = mem_q[synth_cfg_pkg::IDX_SET_EXT + 5'(sel)];
  assign int_code  = {r_ext[synth_cfg_pkg::POS_MINT6], r_ext[synth_cfg_pkg::POS_MINT5],
                      r_cp[synth_cfg_pkg::POS_MINT_LO +: 5]};
  assign frac_code = {r_cp[synth_cfg_pkg::POS_FRAC17], mem_q[synth_cfg_pkg::IDX_FRAC_HI + 5'(sel)],
                      mem_q[synth_cfg_pkg::IDX_FRAC_MID + 5'(sel)],
                      mem_q[synth_cfg_pkg::IDX_POST + 5'(sel)][synth_cfg_pkg::POS_FRAC0]};
  assign pre_code  = {r_ext[synth_cfg_pkg::POS_P2], r_ext[synth_cfg_pkg::POS_P_LO +: 2]};

  // recomputed every cycle, so a write to a field of the selected set shows one cycle after the byte is stored
  always_comb
  begin
    active_set_d     = sel;
    feedback_ratio_d = {int_decode(int_code), frac_code};
    post_ratio_d     = post_decode(mem_q[synth_cfg_pkg::IDX_POST + 5'(sel)][6:0]);
    prescale_half_d  = pre_decode(pre_code);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_set               <= 2'h0;
      feedback_ratio           <= 25'h000_0000;
      post_ratio               <= 7'h00;
      prescale_half            <= 5'h00;
      modulator_enable         <= 1'b0;
      dither_gain              <= 1'b0;
      loop_filter_sel          <= 1'b0;
      pump_current_sel         <= 2'h0;
      loop_enable              <= 1'b0;
      synth_out_drive          <= 1'b0;
      buffered_reference_drive <= 1'b0;
      swing_high               <= 1'b0;
      serial_target_addr       <= 7'h00;
    end
    else
    begin
      active_set               <= active_set_d;
      feedback_ratio           <= feedback_ratio_d;
      post_ratio               <= post_ratio_d;
      prescale_half            <= prescale_half_d;
      modulator_enable         <= r_ext[synth_cfg_pkg::POS_DSM];
      dither_gain              <= r_ext[synth_cfg_pkg::POS_DG];
      loop_filter_sel          <= r_ext[synth_cfg_pkg::POS_LF];
      pump_current_sel         <= r_cp[synth_cfg_pkg::POS_CP +: 2];
      loop_enable              <= mem_q[synth_cfg_pkg::IDX_LOOP_CTL][synth_cfg_pkg::POS_LOOP_EN];
      synth_out_drive          <= ~mem_q[synth_cfg_pkg::IDX_OUT_CTL][synth_cfg_pkg::POS_Q_OFF];
      buffered_reference_drive <= ~mem_q[synth_cfg_pkg::IDX_OUT_CTL][synth_cfg_pkg::POS_REF_OFF];
      swing_high               <= mem_q[synth_cfg_pkg::IDX_OUT_CTL][synth_cfg_pkg::POS_SWING];
      serial_target_addr       <= synth_cfg_pkg::TARGET_ADDR;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_int_range;
    $past(rst_n) |-> feedback_ratio[24:18] >= 7'h04;
  endproperty
  a_int_range: assert property (p_int_range) else $error("integer ratio below four");

  property p_int_low;
    $past(int_code) < 7'h04 && $past(rst_n) |-> feedback_ratio[24:18] == $past(int_code) + 7'h04;
  endproperty
  a_int_low: assert property (p_int_low) else $error("low integer code not offset");

  property p_frac;
    $past(rst_n) |-> feedback_ratio[17:0] == $past(frac_code);
  endproperty
  a_frac: assert property (p_frac) else $error("fraction not passed");

  property p_post_set;
    $past(rst_n) |-> post_ratio >= 7'h02 && (post_ratio <= 7'h06 || !post_ratio[0]);
  endproperty
  a_post_set: assert property (p_post_set) else $error("illegal post ratio");

  property p_post_even;
    $past(mem_q[synth_cfg_pkg::IDX_POST + 5'(sel)][6:1]) >= 6'h03 && $past(sel) == sel && $past(rst_n)
      |-> post_ratio == {$past(mem_q[synth_cfg_pkg::IDX_POST + 5'(sel)][6:1]), 1'b0};
  endproperty
  a_post_even: assert property (p_post_even) else $error("even post ratio wrong");

  property p_pre_mul;
    $past(pre_code[2]) && $past(rst_n) |-> prescale_half == 5'h01;
  endproperty
  a_pre_mul: assert property (p_pre_mul) else $error("multiply code wrong");

  property p_set_follow;
    $changed(sel) |=> active_set == $past(sel);
  endproperty
  a_set_follow: assert property (p_set_follow) else $error("set select not followed");

  property p_q_off;
    access && pwrite && idx == synth_cfg_pkg::IDX_OUT_CTL
      |=> ##1 synth_out_drive == ~$past(pwdata[synth_cfg_pkg::POS_Q_OFF], 2)
      && buffered_reference_drive == ~$past(pwdata[synth_cfg_pkg::POS_REF_OFF], 2);
  endproperty
  a_q_off: assert property (p_q_off) else $error("output disable not applied");

  property p_loop_en;
    access && pwrite && idx == synth_cfg_pkg::IDX_LOOP_CTL
      |=> ##1 loop_enable == $past(pwdata[synth_cfg_pkg::POS_LOOP_EN], 2);
  endproperty
  a_loop_en: assert property (p_loop_en) else $error("loop enable not applied");

  property p_ptr_step;
    access && idx == synth_cfg_pkg::IDX_PORT && ptr_q < synth_cfg_pkg::IDX_LAST |=> ptr_q == $past(ptr_q) + 5'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not ascending");

  property p_target;
    $past(rst_n) |-> serial_target_addr == 7'h6E;
  endproperty
  a_target: assert property (p_target) else $error("target address wrong");

  property p_int_high;
    $past(int_code) >= 7'h04 && $past(rst_n) |-> feedback_ratio[24:18] == $past(int_code);
  endproperty
  a_int_high: assert property (p_int_high) else $error("integer ratio not literal");

  property p_post_low;
    $past(mem_q[synth_cfg_pkg::IDX_POST + 5'(sel)][6:0]) <= 7'h02 && $past(rst_n) |-> post_ratio == 7'h02;
  endproperty
  a_post_low: assert property (p_post_low) else $error("low post code not two");

  property p_pre_div;
    $past(!pre_code[2]) && $past(rst_n) |-> prescale_half == 5'(5'h02 << $past(pre_code[1:0]));
  endproperty
  a_pre_div: assert property (p_pre_div) else $error("input divide code wrong");

  property p_set_bits;
    $past(rst_n) |-> modulator_enable == $past(r_ext[synth_cfg_pkg::POS_DSM])
      && dither_gain == $past(r_ext[synth_cfg_pkg::POS_DG]);
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("modulator bits not passed");

  property p_loop_bits;
    $past(rst_n) |-> pump_current_sel == $past(r_cp[synth_cfg_pkg::POS_CP +: 2])
      && loop_filter_sel == $past(r_ext[synth_cfg_pkg::POS_LF]);
  endproperty
  a_loop_bits: assert property (p_loop_bits) else $error("loop bits not passed");

  property p_swing;
    access && mapped && pwrite && idx == synth_cfg_pkg::IDX_OUT_CTL
      |=> ##1 swing_high == $past(pwdata[synth_cfg_pkg::POS_SWING], 2);
  endproperty
  a_swing: assert property (p_swing) else $error("swing select not applied");

  property p_ptr_wrap;
    access && idx == synth_cfg_pkg::IDX_PORT && ptr_q == synth_cfg_pkg::IDX_LAST |=> ptr_q == 5'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  // the bus answer is fixed at one access cycle, so a ready that never comes would hang the host
  property p_ready_one;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready not a single pulse");

  property p_err;
    psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule : synth_divider_config_decode
`default_nettype wire

// ===== sim/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb master side
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // ---------------------------------------------------------------
  // one transfer, entered just after a rising edge
  // ---------------------------------------------------------------
  // psel stays up on return so a following call starts its setup at once
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    // a call from an idle bus first lines up with the next rising edge
    if (psel !== 1'b1)
      @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait that never sees pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
  endtask : xfer
  // released lines no longer show the last value
  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
    @(posedge clk);
  endtask : idle
endmodule : apb_host_model
`default_nettype wire

// ===== sim/synth_divider_config_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module synth_divider_config_decode_test;
  typedef struct packed {
    logic [6:0] mint; logic [17:0] frac; logic [6:0] post; logic [2:0] pre;
    logic [6:0] e_int; logic [6:0] e_post; logic [4:0] e_pre;
  } row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, modulator_enable, dither_gain, loop_filter_sel;
  logic loop_enable, synth_out_drive, buffered_reference_drive, swing_high;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] active_set, pump_current_sel;
  logic [24:0] feedback_ratio;
  logic [6:0] post_ratio, serial_target_addr;
  logic [4:0] prescale_half;
  int fail_count = 0;
  int total_checks = 0;
  row_s rows [0:10] = '{
    '{7'h00, 18'h0_0000, 7'h00, 3'h0, 7'd4, 7'd2, 5'd2}, '{7'h01, 18'h0_0001, 7'h01, 3'h1, 7'd5, 7'd2, 5'd4},
    '{7'h03, 18'h2_0000, 7'h02, 3'h2, 7'd7, 7'd2, 5'd8}, '{7'h04, 18'h3_ffff, 7'h03, 3'h3, 7'd4, 7'd3, 5'd16},
    '{7'h14, 18'h1_5555, 7'h04, 3'h4, 7'd20, 7'd4, 5'd1}, '{7'h7f, 18'h2_aaaa, 7'h05, 3'h5, 7'd127, 7'd5, 5'd1},
    '{7'h40, 18'h0_8001, 7'h06, 3'h6, 7'd64, 7'd6, 5'd1}, '{7'h20, 18'h1_0000, 7'h07, 3'h7, 7'd32, 7'd6, 5'd1},
    '{7'h64, 18'h0_0100, 7'h10, 3'h0, 7'd100, 7'd16, 5'd2}, '{7'h15, 18'h0_0200, 7'h7f, 3'h1, 7'd21, 7'd126, 5'd4},
    '{7'h16, 18'h0_0004, 7'h09, 3'h2, 7'd22, 7'd8, 5'd8}};
  always #20 clk = ~clk;
  apb_host_model host_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  synth_divider_config_decode dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_set(active_set), .feedback_ratio(feedback_ratio), .post_ratio(post_ratio),
    .prescale_half(prescale_half), .modulator_enable(modulator_enable), .dither_gain(dither_gain),
    .loop_filter_sel(loop_filter_sel), .pump_current_sel(pump_current_sel), .loop_enable(loop_enable),
    .synth_out_drive(synth_out_drive), .buffered_reference_drive(buffered_reference_drive),
    .swing_high(swing_high), .serial_target_addr(serial_target_addr));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    host_u.xfer(1'b1, {1'b0, idx, 2'b00}, {24'h00_0000, d}, r, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, exp, r);
    chk({nm, " err"}, {31'h0, exp_err}, {31'h0, e});
  endtask : rd
  // decoded outputs trail the stored byte by a cycle
  task automatic settle();
    host_u.idle();
    @(posedge clk);
    #1;
  endtask : settle
  task automatic chk_fb(input logic [6:0] i, input logic [17:0] f, input logic [6:0] p, input logic [4:0] h);
    chk("feedback_ratio", {7'h00, i, f}, {7'h00, feedback_ratio});
    chk("post_ratio", {25'h0, p}, {25'h0, post_ratio});
    chk("prescale_half", {27'h0, h}, {27'h0, prescale_half});
  endtask : chk_fb
  task automatic chk_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_fb(7'd4, 18'h0_0000, 7'd2, 5'd2);
    chk("active_set", 32'h0, {30'h0, active_set});
    chk("loop_enable", 32'h1, {31'h0, loop_enable});
    chk("modulator_enable", 32'h1, {31'h0, modulator_enable});
    chk("dither_gain", 32'h0, {31'h0, dither_gain});
    chk("out_drive", 32'h3, {30'h0, synth_out_drive, buffered_reference_drive});
    chk("swing_high", 32'h0, {31'h0, swing_high});
    chk("serial_target_addr", 32'h6e, {25'h0, serial_target_addr});
    rd("loop ctl", 8'h48, 32'h20, 1'b0);
    rd("set ext", 8'h50, 32'h02, 1'b0);
    settle();
  endtask : chk_reset
  initial
  begin
    #(40 * 20000);
    fail_count++;
    results();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [1:0] k;
    row_s rw;
    chk_reset();
    for (int i = 0; i < 11; i++)
    begin
      rw = rows[i];
      k = i[1:0];
      wr(5'h00, {k, rw.mint[4:0], rw.frac[17]});
      wr(5'h04, rw.frac[16:9]);
      wr(5'h08, rw.frac[8:1]);
      wr(5'h0c, {rw.frac[0], rw.post});
      wr(5'h14, {rw.pre[1:0], rw.mint[5], rw.mint[6], rw.pre[2], 1'b1, k[1], k[0]});
      settle();
      chk_fb(rw.e_int, rw.frac, rw.e_post, rw.e_pre);
      chk("dither_gain", 32'h1, {31'h0, dither_gain});
      chk("loop ctl bits", {28'h0, k, k[0], k[1]}, {28'h0, pump_current_sel, loop_filter_sel, modulator_enable});
    end
    // set 2 selected, then one of its fields edited while selected
    wr(5'h02, 8'h64);
    wr(5'h06, 8'h00);
    wr(5'h0a, 8'h00);
    wr(5'h0e, 8'h0a);
    wr(5'h16, 8'ha6);
    wr(5'h12, 8'h30);
    settle();
    chk("active_set", 32'h2, {30'h0, active_set});
    chk_fb(7'd50, 18'h0_0000, 7'd10, 5'd8);
    wr(5'h02, 8'h78);
    settle();
    chk_fb(7'd60, 18'h0_0000, 7'd10, 5'd8);
    wr(5'h12, 8'h00);
    settle();
    chk("loop_enable", 32'h0, {31'h0, loop_enable});
    chk_fb(7'd22, 18'h0_0004, 7'd8, 5'd8);
    wr(5'h12, 8'hff);
    rd("loop ctl", 8'h48, 32'h38, 1'b0);
    for (int v = 0; v < 8; v++)
    begin
      k = v[1:0];
      wr(5'h11, {4'h0, v[2:0], 1'b1});
      settle();
      chk("out_drive", {30'h0, ~v[1], ~v[2]}, {30'h0, synth_out_drive, buffered_reference_drive});
      chk("swing_high", {31'h0, v[0]}, {31'h0, swing_high});
      rd("out ctl", 8'h44, {28'h0, v[2:0], 1'b0}, 1'b0);
    end
    // ascending access through the pointer, wrapping past the last byte
    wr(5'h18, 8'd23);
    wr(5'h19, 8'ha5);
    wr(5'h19, 8'h5a);
    rd("ptr", 8'h60, 32'h01, 1'b0);
    rd("byte 23", 8'h5c, 32'ha5, 1'b0);
    rd("byte 0", 8'h00, 32'h5a, 1'b0);
    wr(5'h18, 8'd30);
    rd("port", 8'h64, 32'h5a, 1'b0);
    rd("ptr", 8'h60, 32'h01, 1'b0);
    wr(5'h10, 8'hff);
    wr(5'h1a, 8'h00);
    rd("reserved", 8'h40, 32'h00, 1'b0);
    rd("target", 8'h68, 32'h6e, 1'b0);
    rd("unmapped", 8'h6c, 32'h00, 1'b1);
    rd("unmapped hi", 8'h80, 32'h00, 1'b1);
    settle();
    chk_reset();
    results();
  end
endmodule : synth_divider_config_decode_test
`default_nettype wire
